//--- hdl/mcsync_params.svh
// constants of the multichip clock synchronization block
// assumes inclusion by bare name from the design files
`ifndef MCSYNC_PARAMS_SVH
`define MCSYNC_PARAMS_SVH

// register addresses
`define ADDR_CONTROL_FUNCTION_TWO 8'h01
`define ADDR_USER_REGISTER_ZERO   8'h1b

// reset values
`define RST_CONTROL_FUNCTION_TWO  32'h0000_0900
`define RST_USER_REGISTER_ZERO    32'h0000_0000

// control_function_two fields
`define SYNC_OUT_ENABLE_BIT       9
`define SYNC_MUX_ENABLE_BIT       8

// user_register_zero fields
`define IN_DELAY_LSB              0
`define OUT_DELAY_LSB             3
`define SYNC_ENABLE_BIT           6

// sync output generator
`define SYNC_OUT_DIVIDE           384
`define SYNC_OUT_HIGH_CYCLES      256

// nominal analog spans of the delay codes, in picoseconds
`define IN_DELAY_SPAN_PS          1200
`define OUT_DELAY_SPAN_PS         1970

// calibration
`define CAL_SYNC_PERIODS          16
`define CLKGEN_PRESET             4'h0

`endif

//--- hdl/mcsync_pkg.sv
// types of the multichip clock synchronization block
// assumes no other package
package mcsync_pkg;

  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_STEP_ONE,
    CAL_WAIT_SYNC,
    CAL_FINISH,
    CAL_DONE
  } cal_state_t;

endpackage

//--- hdl/tap_delay.sv
// selectable tap delay line: code 0 is the shortest path
// assumes a single clock; each code step adds one clock of delay
module tap_delay
#(
  parameter int CODE_W = 3,
  parameter int DEPTH  = 8
)
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // data
  input  wire logic              i_din,
  input  wire logic [CODE_W-1:0] i_code,
  output      logic              o_dout
);

  logic [DEPTH-1:0] tap;
  logic             next_dout;

  generate
    if (DEPTH != (1 << CODE_W))
    begin : g_bad_depth
      $error("tap_delay: DEPTH must equal 2**CODE_W");
    end
  endgenerate

  // ==========================================================
  // tap chain
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_tap
      logic next_tap;
      // the head tap has no neighbour below it, so it is split off
      // rather than indexing tap[-1] in a branch that never runs
      if (gi == 0)
      begin : g_head
        assign next_tap = i_din;
      end
      else
      begin : g_link
        assign next_tap = tap[gi-1];
      end
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          tap[gi] <= 1'b0;
        else
          tap[gi] <= next_tap;
      end
    end
  endgenerate

  // ==========================================================
  // selector, registered
  // ==========================================================
  always_comb
  begin
    next_dout = tap[i_code];
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_dout <= 1'b0;
    else
      o_dout <= next_dout;
  end

endmodule

//--- hdl/multichip_clock_sync.sv
// multichip clock synchronization: sync receiver, sync output generator,
// presettable clock generator and the calibration pause around it
// assumes I_CLK is the core_sample_clock and register writes arrive
// already decoded from the device programming port
`include "mcsync_params.svh"

module multichip_clock_sync
#(
  parameter int CLKGEN_W = 4,
  parameter int DIV_W    = 9
)
(
  // clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  // register access
  input  wire logic                I_REG_WR,
  input  wire logic [7:0]          I_REG_ADDR,
  input  wire logic [31:0]         I_REG_WDATA,
  output      logic [31:0]         O_REG_RDATA,
  // calibration
  input  wire logic                I_CAL_START,
  output      logic                O_CAL_BUSY,
  output      logic                O_CAL_DONE,
  // sync pins
  input  wire logic                I_SYNC_IN,
  output      logic                O_SYNC_OUT,
  output      logic                O_SYNC_OUT_OE,
  // received sync pulse and internal clock generator
  output      logic                O_SYNC_PULSE,
  output      logic [CLKGEN_W-1:0] O_CLK_STATE
);

  localparam int DIVIDE = `SYNC_OUT_DIVIDE;

  generate
    if ((1 << DIV_W) < DIVIDE || CLKGEN_W < 4)
    begin : g_bad_param
      $error("multichip_clock_sync: DIV_W or CLKGEN_W too small");
    end
  endgenerate

  // ==========================================================
  // registers
  // ==========================================================
  logic [31:0] control_function_two;
  logic [31:0] user_register_zero;
  logic [31:0] next_cf2;
  logic [31:0] next_user_register_zero;
  logic [31:0] next_rdata;

  always_comb
  begin
    next_cf2   = control_function_two;
    next_user_register_zero  = user_register_zero;
    next_rdata = 32'h0000_0000;
    if (I_REG_WR && I_REG_ADDR == `ADDR_CONTROL_FUNCTION_TWO)
      next_cf2 = I_REG_WDATA;
    if (I_REG_WR && I_REG_ADDR == `ADDR_USER_REGISTER_ZERO)
      next_user_register_zero = I_REG_WDATA;
    if (I_REG_ADDR == `ADDR_CONTROL_FUNCTION_TWO)
      next_rdata = control_function_two;
    else if (I_REG_ADDR == `ADDR_USER_REGISTER_ZERO)
      next_rdata = user_register_zero;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      control_function_two <= `RST_CONTROL_FUNCTION_TWO;
      user_register_zero   <= `RST_USER_REGISTER_ZERO;
      O_REG_RDATA          <= 32'h0000_0000;
    end
    else
    begin
      control_function_two <= next_cf2;
      user_register_zero   <= next_user_register_zero;
      O_REG_RDATA          <= next_rdata;
    end
  end

  logic       gen_en;
  logic       mux_en;
  logic       sync_en;
  logic [2:0] in_code;
  logic [2:0] out_code;

  assign gen_en   = control_function_two[`SYNC_OUT_ENABLE_BIT];
  assign mux_en   = control_function_two[`SYNC_MUX_ENABLE_BIT];
  assign sync_en  = user_register_zero[`SYNC_ENABLE_BIT];
  assign in_code  = user_register_zero[`IN_DELAY_LSB +: 3];
  assign out_code = user_register_zero[`OUT_DELAY_LSB +: 3];

  // ==========================================================
  // sync receiver
  // ==========================================================
  // the pin is asynchronous to the local clock in practice, so two
  // stages settle it before anything acts on it
  logic sync_meta;
  logic sync_safe;
  logic in_delayed;
  logic in_delayed_q;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sync_meta <= 1'b0;
      sync_safe <= 1'b0;
    end
    else
    begin
      sync_meta <= I_SYNC_IN;
      sync_safe <= sync_meta;
    end
  end

  // one clock of delay per code step keeps the steps monotonic
  tap_delay #(.CODE_W(3), .DEPTH(8)) u_in_delay
  (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_din   (sync_safe),
    .i_code  (in_code),
    .o_dout  (in_delayed)
  );

  logic rise;
  assign rise = in_delayed && !in_delayed_q;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      in_delayed_q <= 1'b0;
      O_SYNC_PULSE <= 1'b0;
    end
    else
    begin
      in_delayed_q <= in_delayed;
      O_SYNC_PULSE <= rise;
    end
  end

  // ==========================================================
  // sync output generator
  // ==========================================================
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             gen_level;
  logic             gen_delayed;

  always_comb
  begin
    if (div_cnt == DIV_W'(DIVIDE - 1))
      next_div_cnt = '0;
    else
      next_div_cnt = div_cnt + DIV_W'(1);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      div_cnt   <= '0;
      gen_level <= 1'b0;
    end
    else
    begin
      div_cnt   <= next_div_cnt;
      gen_level <= (div_cnt < DIV_W'(`SYNC_OUT_HIGH_CYCLES));
    end
  end

  tap_delay #(.CODE_W(3), .DEPTH(8)) u_out_delay
  (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_din   (gen_level),
    .i_code  (out_code),
    .o_dout  (gen_delayed)
  );

  // ==========================================================
  // output pin mux
  // ==========================================================
  logic next_pin;
  logic next_oe;

  always_comb
  begin
    next_pin = 1'b0;
    next_oe  = 1'b0;
    if (gen_en && mux_en)
    begin
      next_pin = gen_delayed;
      next_oe  = 1'b1;
    end
    else if (!gen_en)
    begin
      next_pin = sync_safe;
      next_oe  = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_SYNC_OUT    <= 1'b0;
      O_SYNC_OUT_OE <= 1'b0;
    end
    else
    begin
      O_SYNC_OUT    <= next_pin;
      O_SYNC_OUT_OE <= next_oe;
    end
  end

  // ==========================================================
  // calibration sequence
  // ==========================================================
  // without a sync signal and with sync enabled the pause never ends;
  // that is intended, software must see calibration stall
  mcsync_pkg::cal_state_t cal_state;
  mcsync_pkg::cal_state_t next_cal_state;
  logic [4:0]             sync_seen;
  logic [4:0]             next_sync_seen;
  logic                   do_preset;

  assign do_preset = (cal_state == mcsync_pkg::CAL_WAIT_SYNC) &&
                     sync_en && O_SYNC_PULSE;

  always_comb
  begin
    next_cal_state = cal_state;
    next_sync_seen = sync_seen;
    unique case (cal_state)
      mcsync_pkg::CAL_IDLE,
      mcsync_pkg::CAL_DONE:
        if (I_CAL_START)
          next_cal_state = mcsync_pkg::CAL_STEP_ONE;
      mcsync_pkg::CAL_STEP_ONE:
      begin
        next_sync_seen = 5'h00;
        next_cal_state = sync_en ? mcsync_pkg::CAL_WAIT_SYNC
                                 : mcsync_pkg::CAL_FINISH;
      end
      mcsync_pkg::CAL_WAIT_SYNC:
        if (do_preset)
        begin
          next_sync_seen = sync_seen + 5'h01;
          if (sync_seen == 5'(`CAL_SYNC_PERIODS - 1))
            next_cal_state = mcsync_pkg::CAL_FINISH;
        end
      mcsync_pkg::CAL_FINISH:
        next_cal_state = mcsync_pkg::CAL_DONE;
      default:
        next_cal_state = mcsync_pkg::CAL_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cal_state  <= mcsync_pkg::CAL_IDLE;
      sync_seen  <= 5'h00;
      O_CAL_BUSY <= 1'b0;
      O_CAL_DONE <= 1'b0;
    end
    else
    begin
      cal_state  <= next_cal_state;
      sync_seen  <= next_sync_seen;
      O_CAL_BUSY <= (next_cal_state != mcsync_pkg::CAL_IDLE) &&
                    (next_cal_state != mcsync_pkg::CAL_DONE);
      O_CAL_DONE <= (next_cal_state == mcsync_pkg::CAL_DONE);
    end
  end

  // ==========================================================
  // presettable internal clock generator
  // ==========================================================
  logic [CLKGEN_W-1:0] next_clk_state;

  always_comb
  begin
    if (do_preset)
      next_clk_state = CLKGEN_W'(`CLKGEN_PRESET);
    else
      next_clk_state = O_CLK_STATE + CLKGEN_W'(1);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_CLK_STATE <= '0;
    else
      O_CLK_STATE <= next_clk_state;
  end

endmodule

//--- sim/mcsync_monitor.sv
// port checker of the multichip sync block
// assumes it is bound onto every multichip_clock_sync
`include "mcsync_params.svh"
// ================
// checker
module mcsync_monitor
#(
  parameter int CLKGEN_W = 4
)
(
  input wire logic                I_CLK,
  input wire logic                I_RST_N,
  input wire logic [7:0]          I_REG_ADDR,
  input wire logic [31:0]         O_REG_RDATA,
  input wire logic                I_CAL_START,
  input wire logic                O_CAL_BUSY,
  input wire logic                O_CAL_DONE,
  input wire logic                O_SYNC_OUT,
  input wire logic                O_SYNC_OUT_OE,
  input wire logic                O_SYNC_PULSE,
  input wire logic [CLKGEN_W-1:0] O_CLK_STATE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  pulse_width_a: assert property (O_SYNC_PULSE |=> !O_SYNC_PULSE)
    else $error("sync pulse too long");
  preset_a: assert property (O_SYNC_PULSE && O_CAL_BUSY
    && $past(O_CAL_BUSY) |=> O_CLK_STATE == `CLKGEN_PRESET)
    else $error("counter not preset");
  count_step_a: assert property ($past(I_RST_N) && !$past(O_SYNC_PULSE)
    |-> O_CLK_STATE == CLKGEN_W'($past(O_CLK_STATE) + 1))
    else $error("counter did not step");
  idle_low_a: assert property (!O_SYNC_OUT_OE |-> !O_SYNC_OUT)
    else $error("pin level while not driven");
  cal_excl_a: assert property (!(O_CAL_BUSY && O_CAL_DONE))
    else $error("busy and done together");
  done_hold_a: assert property (O_CAL_DONE && !I_CAL_START
    |=> O_CAL_DONE)
    else $error("done dropped");
  busy_cause_a: assert property ($rose(O_CAL_BUSY)
    |-> $past(I_CAL_START))
    else $error("busy without start");
  unmapped_a: assert property (
    $past(I_REG_ADDR) != `ADDR_CONTROL_FUNCTION_TWO
    && $past(I_REG_ADDR) != `ADDR_USER_REGISTER_ZERO
    |-> O_REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  cover property (O_SYNC_PULSE && O_CAL_BUSY);
  cover property ($rose(O_CAL_DONE));
  cover property ($fell(O_SYNC_OUT_OE));
endmodule
bind multichip_clock_sync mcsync_monitor #(.CLKGEN_W(CLKGEN_W)) mon_u (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR),
  .O_REG_RDATA(O_REG_RDATA), .I_CAL_START(I_CAL_START),
  .O_CAL_BUSY(O_CAL_BUSY), .O_CAL_DONE(O_CAL_DONE),
  .O_SYNC_OUT(O_SYNC_OUT), .O_SYNC_OUT_OE(O_SYNC_OUT_OE),
  .O_SYNC_PULSE(O_SYNC_PULSE), .O_CLK_STATE(O_CLK_STATE));

//--- sim/sync_source.sv
// sync reference standing in for the board distribution
// assumes the bench clock; moves only after rising edges
// ================
// source
module sync_source
(
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic       i_fb_sel,
  input  wire logic       i_fb,
  input  wire logic [7:0] i_half,
  output      logic       o_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  logic       gen = 1'b0;
  wire        wrap = (cnt + 8'h01 >= i_half);
  // stopped source rests low, no free-running clock
  always @(posedge i_clk)
  begin
    cnt <= (!i_run || wrap) ? 8'h00 : cnt + 8'h01;
    gen <= i_run && (wrap ? ~gen : gen);
  end
  assign o_sync = i_fb_sel ? i_fb : gen;
endmodule

//--- sim/multichip_clock_sync_test.sv
// self-checking bench of the multichip sync block
// assumes the design, its header and the bound checker
`include "mcsync_params.svh"
// ================
// bench
module multichip_clock_sync_test;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(n,e,s) begin n_tests++; if ((e) !== (s)) begin err_count++; \
 $display("[ERR] %s exp %0h got %0h", n, e, s); end end
  logic        I_CLK = 0, I_RST_N = 0, I_REG_WR = 0, I_CAL_START = 0;
  logic [7:0]  I_REG_ADDR = 0;
  logic [31:0] I_REG_WDATA = 0, w, ex, q[$];
  logic        O_CAL_BUSY, O_CAL_DONE, O_SYNC_OUT, O_SYNC_OUT_OE;
  logic        O_SYNC_PULSE, I_SYNC_IN, run = 0, fb = 0, rd_v = 0;
  logic        chk_lat = 0;
  logic [31:0] O_REG_RDATA;
  logic [3:0]  O_CLK_STATE;
  logic [2:0]  h = 0;
  int          err_count = 0, n_tests = 0, cyc = 0, t0 = 0, code = 0;
  int          npls = 0, hi, r0, r1, seed = 58439;
  always #25 I_CLK = ~I_CLK;
  multichip_clock_sync dut_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_REG_WR(I_REG_WR), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
    .I_CAL_START(I_CAL_START), .O_CAL_BUSY(O_CAL_BUSY),
    .O_CAL_DONE(O_CAL_DONE), .I_SYNC_IN(I_SYNC_IN),
    .O_SYNC_OUT(O_SYNC_OUT), .O_SYNC_OUT_OE(O_SYNC_OUT_OE),
    .O_SYNC_PULSE(O_SYNC_PULSE), .O_CLK_STATE(O_CLK_STATE));
  sync_source src_u (.i_clk(I_CLK), .i_run(run), .i_fb_sel(fb),
    .i_fb(O_SYNC_OUT), .i_half(8'h0a), .o_sync(I_SYNC_IN));
  task stop_test;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_REG_WR <= 1;
    I_REG_ADDR <= a;
    I_REG_WDATA <= d;
    @(posedge I_CLK);
    I_REG_WR <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge I_CLK);
    I_REG_ADDR <= a;
    @(posedge I_CLK);
    q.push_back(e);
    rd_v <= 1;
    @(posedge I_CLK);
    rd_v <= 0;
  endtask
  task cal;
    @(posedge I_CLK);
    I_CAL_START <= 1;
    @(posedge I_CLK);
    I_CAL_START <= 0;
  endtask
  // edge finder on the pin; gives -1 when no edge shows up
  task rise(output int r);
    logic p;
    p = 1;
    r = -1;
    for (int k = 0; k < 800 && r < 0; k++)
    begin
      @(posedge I_CLK);
      #1;
      if (O_SYNC_OUT === 1'b1 && !p)
        r = cyc;
      p = O_SYNC_OUT;
    end
  endtask
  // watcher: read results off the queue, pulse latency, timeout
  always @(posedge I_CLK)
  begin
    cyc++;
    h <= {h[1:0], I_SYNC_IN};
    if (I_SYNC_IN && !h[0])
      t0 = cyc;
    if (rd_v)
    begin
      ex = q.pop_front();
      `CHK("rdata", ex, O_REG_RDATA)
    end
    if (O_SYNC_PULSE && chk_lat)
      `CHK("latency", 5 + code, cyc - t0)
    if (O_SYNC_PULSE && O_CAL_BUSY)
      npls++;
    if (cyc > 30000)
    begin
      err_count++;
      stop_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge I_CLK);
    I_RST_N <= 1;
    rd(8'h01, `RST_CONTROL_FUNCTION_TWO);
    rd(8'h1b, `RST_USER_REGISTER_ZERO);
    w = $random(seed);
    wr(8'h1b, w);
    rd(8'h1b, w);
    wr(8'h7e, w);
    rd(8'h7e, 32'h0);
    run <= 1;
    `CHK("oe", 1'b1, O_SYNC_OUT_OE)
    repeat (30)
    begin
      @(posedge I_CLK);
      #1 `CHK("buf", h[2], O_SYNC_OUT)
    end
    // code changes mid-period would skew one edge, so skip it
    for (int c = 0; c < 8; c++)
    begin
      chk_lat = 0;
      code = c;
      wr(8'h1b, 32'(c));
      repeat (25) @(posedge I_CLK);
      chk_lat = 1;
      repeat (40) @(posedge I_CLK);
    end
    chk_lat = 0;
    run <= 0;
    wr(8'h1b, 32'h0);
    wr(8'h01, 32'h300);
    repeat (2) @(posedge I_CLK);
    #1 `CHK("oe_gen", 1'b1, O_SYNC_OUT_OE)
    rise(r0);
    hi = 0;
    repeat (384)
    begin
      @(posedge I_CLK);
      hi += O_SYNC_OUT;
    end
    `CHK("duty", 256, hi)
    rise(r1);
    `CHK("period", 768, r1 - r0)
    wr(8'h1b, 32'h38);
    repeat (400) @(posedge I_CLK);
    rise(r1);
    `CHK("odelay", 7, (r1 - r0) % 384)
    wr(8'h01, 32'h200);
    repeat (2) @(posedge I_CLK);
    #1 `CHK("oe_off", 1'b0, O_SYNC_OUT_OE)
    wr(8'h1b, 32'h0);
    cal;
    @(posedge I_CLK);
    #1 `CHK("busy", 1'b1, O_CAL_BUSY)
    repeat (2) @(posedge I_CLK);
    #1 `CHK("done", 1'b1, O_CAL_DONE)
    wr(8'h1b, 32'h40);
    cal;
    repeat (2000) @(posedge I_CLK);
    #1 `CHK("stall", 1'b0, O_CAL_DONE)
    wr(8'h01, 32'h300);
    fb <= 1;
    npls = 0;
    for (int k = 0; k < 8000 && O_CAL_DONE !== 1'b1; k++)
      @(posedge I_CLK);
    `CHK("cal_sync", 1'b1, O_CAL_DONE)
    `CHK("presets", 16, npls)
    #1 `CHK("clk_state", 4'(`CLKGEN_PRESET + 2), O_CLK_STATE)
    stop_test;
  end
endmodule
